/* File: hw/source_aux_link_training.sv */
// Purpose: sideband request engine, hot plug events and training controls
// Assumes: AXI4-Lite slave on clk, line coding of the sideband kept simple
// Notes: each data bit is two half-bit ticks, bit then its complement
`timescale 1ns/100ps
`include "source_aux_link_training_map.svh"
module source_aux_link_training import sideband_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic auxIn,
  output logic auxOut,
  output logic auxOe,
  input wire logic hpdIn,
  input wire logic blankStart,
  output logic linkOutEnable,
  output logic [1:0] lanePattern,
  output logic datapathBlocked,
  output logic scramblerBypass,
  output logic scramblerReinit,
  output logic streamEnable,
  output logic eventPending
);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction
  function automatic logic isOfs(input logic [11:0] a, input logic [11:0] o);
    isOfs = (a[11:2] == o[11:2]);
  endfunction
  logic awready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] linkRate_q, divisor_q;
  logic [1:0] pattern_q;
  logic scrOff_q, outEn_q, streamEn_q, scrReinit_q, pending_q;
  logic [19:0] sbAddr_q;
  logic [12:0] cmd_q;
  logic [4:0] status_q, mask_q;
  logic [3:0] replyCode_q;
  byte_t wMem [`FIFO_DEPTH];
  byte_t rMem [`FIFO_DEPTH];
  logic [4:0] wCnt_q, rCnt_q;
  logic [3:0] rWr_q, rRd_q;
  sb_state_t state_q;
  logic [7:0] divCnt_q, shift_q;
  logic [3:0] half_q;
  logic [4:0] byteIdx_q;
  logic [8:0] waitCnt_q;
  logic auxOut_q, auxOe_q, sbTick_q;
  logic [2:0] auxSync_q, hpdSync_q;
  logic auxLvl_q, hpdLvl_q, hpdPrev_q;
  logic [11:0] lowCnt_q;
  logic [9:0] bsCnt_q;
  wire wrTake = awready_q & s_axi_awvalid & s_axi_wvalid;
  wire rdTake = arready_q & s_axi_arvalid;
  wire [11:0] wa = s_axi_awaddr;
  wire [11:0] ra = s_axi_araddr;
  wire busy = ~state_q[0];
  wire wrCmd = wrTake & isOfs(wa, `OFS_SB_COMMAND) & ~busy;
  wire wrPush = wrTake & isOfs(wa, `OFS_SB_WFIFO) & ~busy & (wCnt_q < 5'd16);
  wire rdPop = rdTake & isOfs(ra, `OFS_SB_RDATA) & (rCnt_q != 5'd0);
  wire rdStatus = rdTake & isOfs(ra, `OFS_EVT_STATUS);
  wire wrScr = wrTake & isOfs(wa, `OFS_SCR_RESET) & s_axi_wstrb[0] & s_axi_wdata[0];
  wire wrMapped = isOfs(wa, `OFS_LINK_RATE) | isOfs(wa, `OFS_TRAIN_PATTERN)
    | isOfs(wa, `OFS_SCRAMBLE_OFF) | isOfs(wa, `OFS_LINK_OUT_EN) | isOfs(wa, `OFS_STREAM_EN)
    | isOfs(wa, `OFS_SCR_RESET) | isOfs(wa, `OFS_SB_COMMAND) | isOfs(wa, `OFS_SB_WFIFO)
    | isOfs(wa, `OFS_SB_ADDRESS) | isOfs(wa, `OFS_SB_DIVISOR) | isOfs(wa, `OFS_EVT_MASK);
  wire [31:0] wMerged = merge(32'h0, s_axi_wdata, s_axi_wstrb);
  wire [31:0] addrMerged = merge({12'h0, sbAddr_q}, s_axi_wdata, s_axi_wstrb);
  // Command decode: bit 12 strips the length byte, bit 8 marks a read
  wire addrOnly = cmd_q[`CMD_ADDR_ONLY_BIT];
  wire isRead = cmd_q[8];
  wire [4:0] sendBytes = addrOnly ? 5'd3 : (isRead ? 5'd4 : 5'd4 + wCnt_q);
  wire [4:0] recvBytes = (isRead & ~addrOnly) ? 5'd2 + {1'b0, cmd_q[3:0]} : 5'd1;
  wire [4:0] dataIdx = byteIdx_q - 5'd4;
  wire [7:0] lenByte = isRead ? {4'h0, cmd_q[3:0]} : {3'h0, wCnt_q - 5'd1};
  wire [7:0] curByte = (byteIdx_q == 5'd0) ? {cmd_q[11:8], sbAddr_q[19:16]} :
                       (byteIdx_q == 5'd1) ? sbAddr_q[15:8] :
                       (byteIdx_q == 5'd2) ? sbAddr_q[7:0] :
                       (byteIdx_q == 5'd3) ? lenByte : wMem[dataIdx[3:0]];
  wire txBit = curByte[3'd7 - half_q[3:1]] ^ half_q[0];
  wire lastHalf = (half_q == 4'hf);
  wire timedOut = sbTick_q & (waitCnt_q == 9'(`SB_TIMEOUT_TICKS - 1));
  wire rxDone = sbTick_q & lastHalf & (byteIdx_q + 5'd1 == recvBytes);
  // Hot plug events: short low is a pulse, long low a disconnect
  wire hpdRise = hpdLvl_q & ~hpdPrev_q;
  wire hpdShort = lowCnt_q < 12'(`HPD_PULSE_TICKS);
  wire evConnect = hpdRise & ~hpdShort;
  wire evPulse = hpdRise & hpdShort;
  wire evDisconnect = ~hpdLvl_q & sbTick_q & (lowCnt_q == 12'(`HPD_PULSE_TICKS - 1));
  wire evReply = (state_q == SB_RECV) & rxDone & ~timedOut;
  wire evTimeout = (state_q != SB_IDLE) & (state_q != SB_SEND) & timedOut;
  wire [4:0] evSet = {evTimeout, evReply, evPulse, evDisconnect, evConnect};
  wire [4:0] statusD = (status_q & ~(rdStatus ? status_q : 5'h0)) | evSet;
  wire bsWrap = streamEn_q & blankStart & (bsCnt_q == `BS_PERIOD - 10'd1);
  wire topRate = (linkRate_q == `LINK_RATE_TOP);
  wire [31:0] rdMux =
    isOfs(ra, `OFS_LINK_RATE) ? {24'h0, linkRate_q} :
    isOfs(ra, `OFS_TRAIN_PATTERN) ? {30'h0, pattern_q} :
    isOfs(ra, `OFS_SCRAMBLE_OFF) ? {31'h0, scrOff_q} :
    isOfs(ra, `OFS_LINK_OUT_EN) ? {31'h0, outEn_q} :
    isOfs(ra, `OFS_STREAM_EN) ? {31'h0, streamEn_q} :
    isOfs(ra, `OFS_SB_COMMAND) ? {19'h0, cmd_q} :
    isOfs(ra, `OFS_SB_ADDRESS) ? {12'h0, sbAddr_q} :
    isOfs(ra, `OFS_SB_DIVISOR) ? {24'h0, divisor_q} :
    isOfs(ra, `OFS_SB_STATE) ? {24'h0, rCnt_q, hpdLvl_q, wCnt_q == 5'h0, busy} :
    isOfs(ra, `OFS_SB_RDATA) ? {24'h0, rMem[rRd_q]} :
    isOfs(ra, `OFS_SB_RCODE) ? {28'h0, replyCode_q} :
    isOfs(ra, `OFS_EVT_STATUS) ? {27'h0, status_q} :
    isOfs(ra, `OFS_EVT_MASK) ? {27'h0, mask_q} : 32'h0;
  wire rdMapped = isOfs(ra, `OFS_LINK_RATE) | isOfs(ra, `OFS_TRAIN_PATTERN)
    | isOfs(ra, `OFS_SCRAMBLE_OFF) | isOfs(ra, `OFS_LINK_OUT_EN) | isOfs(ra, `OFS_STREAM_EN)
    | isOfs(ra, `OFS_SB_COMMAND) | isOfs(ra, `OFS_SB_ADDRESS) | isOfs(ra, `OFS_SB_DIVISOR)
    | isOfs(ra, `OFS_SB_STATE) | isOfs(ra, `OFS_SB_RDATA) | isOfs(ra, `OFS_SB_RCODE)
    | isOfs(ra, `OFS_EVT_STATUS) | isOfs(ra, `OFS_EVT_MASK);
  // Bus handshake: one write and one read at a time, answer in the cycle after the take
  always_ff @(posedge clk) begin
    if (rst) begin
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0;
    end else begin
      awready_q <= s_axi_awvalid & s_axi_wvalid & ~bvalid_q & ~awready_q;
      if (wrTake) begin
        bvalid_q <= 1'b1;
        bresp_q <= wrMapped ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      arready_q <= s_axi_arvalid & ~rvalid_q & ~arready_q;
      if (rdTake) begin
        rvalid_q <= 1'b1;
        rresp_q <= rdMapped ? 2'h0 : 2'h2;
        rdata_q <= rdMux;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  // Control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      linkRate_q <= 8'h0;
      pattern_q <= 2'h0;
      scrOff_q <= 1'b0;
      outEn_q <= 1'b0;
      streamEn_q <= 1'b0;
      sbAddr_q <= 20'h0;
      divisor_q <= `RST_DIVISOR;
      mask_q <= `RST_MASK;
      status_q <= 5'h0;
      pending_q <= 1'b0;
    end else begin
      if (wrTake & ~busy) begin
        if (isOfs(wa, `OFS_LINK_RATE) & s_axi_wstrb[0]) linkRate_q <= wMerged[7:0];
        if (isOfs(wa, `OFS_TRAIN_PATTERN) & s_axi_wstrb[0]) pattern_q <= wMerged[1:0];
        if (isOfs(wa, `OFS_SCRAMBLE_OFF) & s_axi_wstrb[0]) scrOff_q <= wMerged[0];
        if (isOfs(wa, `OFS_LINK_OUT_EN) & s_axi_wstrb[0]) outEn_q <= wMerged[0];
        if (isOfs(wa, `OFS_STREAM_EN) & s_axi_wstrb[0]) streamEn_q <= wMerged[0];
        if (isOfs(wa, `OFS_SB_ADDRESS)) sbAddr_q <= addrMerged[19:0];
        if (isOfs(wa, `OFS_SB_DIVISOR) & s_axi_wstrb[0]) divisor_q <= wMerged[7:0];
        if (isOfs(wa, `OFS_EVT_MASK) & s_axi_wstrb[0]) mask_q <= wMerged[4:0];
      end
      status_q <= statusD;
      pending_q <= |(status_q & ~mask_q);
    end
  end
  // Training: pattern 2 becomes pattern 3 at the top rate
  always_ff @(posedge clk) begin
    if (rst) begin
      lanePattern <= 2'h0;
      datapathBlocked <= 1'b0;
      bsCnt_q <= 10'h0;
      scrReinit_q <= 1'b0;
    end else begin
      lanePattern <= (pattern_q == 2'h2 && topRate) ? 2'h3 : pattern_q;
      datapathBlocked <= (pattern_q != 2'h0);
      if (!streamEn_q) bsCnt_q <= 10'h0;
      else if (blankStart) bsCnt_q <= bsWrap ? 10'h0 : bsCnt_q + 10'd1;
      scrReinit_q <= wrScr | bsWrap;
    end
  end
  // Sample tick divider
  always_ff @(posedge clk) begin
    if (rst) begin
      divCnt_q <= 8'h0;
      sbTick_q <= 1'b0;
    end else begin
      sbTick_q <= (divCnt_q + 8'd1 >= divisor_q);
      divCnt_q <= (divCnt_q + 8'd1 >= divisor_q) ? 8'h0 : divCnt_q + 8'd1;
    end
  end
  // Pin synchronisers; level moves once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      auxSync_q <= 3'h0;
      hpdSync_q <= 3'h0;
      auxLvl_q <= 1'b0;
      hpdLvl_q <= 1'b0;
      hpdPrev_q <= 1'b0;
      lowCnt_q <= 12'h0;
    end else begin
      auxSync_q <= {auxSync_q[1:0], auxIn};
      hpdSync_q <= {hpdSync_q[1:0], hpdIn};
      if (auxSync_q[1] == auxSync_q[2]) auxLvl_q <= auxSync_q[2];
      if (hpdSync_q[1] == hpdSync_q[2]) hpdLvl_q <= hpdSync_q[2];
      hpdPrev_q <= hpdLvl_q;
      if (hpdLvl_q) lowCnt_q <= 12'h0;
      else if (sbTick_q && lowCnt_q != 12'hfff) lowCnt_q <= lowCnt_q + 12'd1;
    end
  end
  // Request engine
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SB_IDLE;
      cmd_q <= 13'h0;
      half_q <= 4'h0;
      byteIdx_q <= 5'h0;
      shift_q <= 8'h0;
      waitCnt_q <= 9'h0;
      auxOut_q <= 1'b0;
      auxOe_q <= 1'b0;
      replyCode_q <= 4'h0;
      wCnt_q <= 5'h0;
      rCnt_q <= 5'h0;
      rWr_q <= 4'h0;
      rRd_q <= 4'h0;
    end else begin
      if (wrPush) begin
        wMem[wCnt_q[3:0]] <= s_axi_wdata[7:0];
        wCnt_q <= wCnt_q + 5'd1;
      end
      if (rdPop) begin
        rRd_q <= rRd_q + 4'd1;
        rCnt_q <= rCnt_q - 5'd1;
      end
      unique case (state_q)
        SB_IDLE: begin
          if (wrCmd) begin
            cmd_q <= wMerged[12:0];
            state_q <= SB_SEND;
            half_q <= 4'h0;
            byteIdx_q <= 5'h0;
            rCnt_q <= 5'h0;
            rWr_q <= 4'h0;
            rRd_q <= 4'h0;
          end
        end
        SB_SEND: begin
          if (sbTick_q) begin
            auxOe_q <= 1'b1;
            auxOut_q <= txBit;
            half_q <= half_q + 4'd1;
            if (lastHalf) begin
              byteIdx_q <= byteIdx_q + 5'd1;
              if (byteIdx_q + 5'd1 == sendBytes) begin
                state_q <= SB_WAIT;
                waitCnt_q <= 9'h0;
                wCnt_q <= 5'h0;
              end
            end
          end
        end
        SB_WAIT: begin
          if (sbTick_q) begin
            auxOe_q <= 1'b0;
            auxOut_q <= 1'b0;
            waitCnt_q <= waitCnt_q + 9'd1;
            if (timedOut) state_q <= SB_IDLE;
            else if (auxLvl_q && !auxOe_q) begin
              state_q <= SB_RECV;
              half_q <= 4'h0;
              byteIdx_q <= 5'h0;
            end
          end
        end
        SB_RECV: begin
          if (sbTick_q) begin
            waitCnt_q <= waitCnt_q + 9'd1;
            half_q <= half_q + 4'd1;
            // Only the first half of each bit carries data
            if (!half_q[0]) shift_q <= {shift_q[6:0], auxLvl_q};
            if (lastHalf) begin
              byteIdx_q <= byteIdx_q + 5'd1;
              if (byteIdx_q == 5'd0) replyCode_q <= shift_q[7:4];
              else if (rCnt_q < 5'd16) begin
                rMem[rWr_q] <= shift_q;
                rWr_q <= rWr_q + 4'd1;
                rCnt_q <= rCnt_q + 5'd1 - {4'h0, rdPop};
              end
            end
            if (rxDone || timedOut) state_q <= SB_IDLE;
          end
        end
      endcase
    end
  end
  assign s_axi_awready = awready_q;
  assign s_axi_wready = awready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign auxOut = auxOut_q;
  assign auxOe = auxOe_q;
  assign linkOutEnable = outEn_q;
  assign scramblerBypass = scrOff_q;
  assign scramblerReinit = scrReinit_q;
  assign streamEnable = streamEn_q;
  assign eventPending = pending_q;
endmodule

/* File: hw/source_aux_link_training_map.svh */
// Purpose: offsets, reset values and timing counts of the sideband and training block
// Assumes: 250 MHz register clock, 1 MHz sideband sample rate
// Notes: byte addresses on the AXI4-Lite port
// Functional notes
// - Mask value zero leaves hot plug connect, disconnect and pulse events unmasked.
// - Training mode blocks the functional datapath and drives the chosen pattern.
// - Pattern select: 1 clock recovery, 2 symbol lock and alignment, 0 normal.
// - Scrambler disable 1 bypasses scrambling, 0 restores it.
// - At highest link rate the third pattern replaces the second.
// - With video enabled the scrambler reinitialises every 512th blanking start.
// - Writing one to scrambler reset forces an immediate reinitialisation.
// - Register clock divided by the divisor gives the 1 MHz sample tick.
// - A command write launches a request with loaded address and data.
// - Command 0x08 sends the write FIFO bytes to the programmed address.
// - Reply received and reply timeout are flagged in the status register.
// - Reply code holds the sink response, zero meaning acknowledged.
// - A read command write carries both command and byte count.
// - Reply data is one address over a 16 byte FIFO, read pops.
// - Command register at 0x100, bit 12 selects address-only or write status.
`ifndef SOURCE_AUX_LINK_TRAINING_MAP_SVH
`define SOURCE_AUX_LINK_TRAINING_MAP_SVH
`define OFS_LINK_RATE 12'h000
`define OFS_TRAIN_PATTERN 12'h00c
`define OFS_SCRAMBLE_OFF 12'h014
`define OFS_LINK_OUT_EN 12'h080
`define OFS_STREAM_EN 12'h084
`define OFS_SCR_RESET 12'h0c0
`define OFS_SB_COMMAND 12'h100
`define OFS_SB_WFIFO 12'h104
`define OFS_SB_ADDRESS 12'h108
`define OFS_SB_DIVISOR 12'h10c
`define OFS_SB_STATE 12'h130
`define OFS_SB_RDATA 12'h134
`define OFS_SB_RCODE 12'h138
`define OFS_EVT_STATUS 12'h140
`define OFS_EVT_MASK 12'h144
`define RST_DIVISOR 8'hfa
`define RST_MASK 5'h1f
`define CMD_ADDR_ONLY_BIT 12
`define LINK_RATE_TOP 8'h14
`define BS_PERIOD 10'h200
`define CLK_MHZ 250
`define SB_RATE_MHZ 1
`define SB_TIMEOUT_US 400
`define SB_TIMEOUT_TICKS (`SB_TIMEOUT_US * `SB_RATE_MHZ)
`define HPD_PULSE_MAX_US 2000
`define HPD_PULSE_TICKS (`HPD_PULSE_MAX_US * `SB_RATE_MHZ)
`define FIFO_DEPTH 16
`endif

/* File: hw/sideband_pkg.sv */
// Purpose: types of the sideband and training block
// Assumes: nothing
// Notes: one-hot request engine states
package sideband_pkg;
  typedef enum logic [3:0] {
    SB_IDLE = 4'b0001,
    SB_SEND = 4'b0010,
    SB_WAIT = 4'b0100,
    SB_RECV = 4'b1000
  } sb_state_t;
  typedef logic [7:0] byte_t;
endpackage

/* File: dv/source_aux_link_training_sva.sv */
// Purpose: port checker of the sideband and training block
// Assumes: offsets of the map header
// Notes: sideband half width is checked only while the divisor holds 4
`timescale 1ns/100ps
`include "source_aux_link_training_map.svh"
module source_aux_link_training_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic auxOut,
  input wire logic auxOe,
  input wire logic [1:0] lanePattern,
  input wire logic datapathBlocked,
  input wire logic scramblerBypass,
  input wire logic scramblerReinit,
  input wire logic eventPending
);
  logic maskSet_q;
  logic bypass_q;
  logic [31:0] div_q;
  wire wrTake = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  // Mirrors of written values; the bench never writes these while a request is busy
  always_ff @(posedge clk) begin
    if (rst) begin
      maskSet_q <= 1'b0;
      bypass_q <= 1'b0;
      div_q <= 32'hfa;
    end else if (wrTake) begin
      if (s_axi_awaddr == `OFS_EVT_MASK) maskSet_q <= 1'b1;
      if (s_axi_awaddr == `OFS_SCRAMBLE_OFF) bypass_q <= s_axi_wdata[0];
      if (s_axi_awaddr == `OFS_SB_DIVISOR) div_q <= s_axi_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence wrAt(logic [11:0] a);
    wrTake && s_axi_awaddr == a;
  endsequence
  a_write_answer: assert property (wrTake |=> s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_ready_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("address and data ready differ");
  a_block_follows: assert property (datapathBlocked == (lanePattern != 2'h0))
    else $error("datapath block wrong");
  a_bypass_follows: assert property (wrAt(`OFS_SCRAMBLE_OFF) |=> ##[0:1] scramblerBypass == bypass_q)
    else $error("bypass not following write");
  a_reinit_single: assert property (scramblerReinit |=> !scramblerReinit)
    else $error("reinit longer than one cycle");
  a_reinit_force: assert property (wrAt(`OFS_SCR_RESET) ##0 s_axi_wdata[0] |-> ##[1:3] scramblerReinit)
    else $error("forced reinit missing");
  a_half_width: assert property (auxOe && div_q == 32'h4 && $changed(auxOut) |=> $stable(auxOut)[*3])
    else $error("sideband half too short");
  a_mask_quiet: assert property (!maskSet_q |-> !eventPending)
    else $error("event pending while masked");
endmodule

bind source_aux_link_training source_aux_link_training_sva source_aux_link_training_sva_inst (
  .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .auxOut, .auxOe,
  .lanePattern, .datapathBlocked, .scramblerBypass, .scramblerReinit, .eventPending);

/* File: dv/aux_sink_model.sv */
// Purpose: behavioural sink on the sideband line
// Assumes: source halves last DIV cycles; each bit is sent as bit then complement
// Notes: line is pulled low when released
`timescale 1ns/100ps
module aux_sink_model #(parameter int DIV = 4) (
  input wire logic clk,
  input wire logic auxOut,
  input wire logic auxOe,
  input wire logic [3:0] replyCode,
  input wire logic silent,
  input wire logic [15:0] replyDelay,
  output logic auxIn
);
  logic [7:0] reqBytes [0:15];
  logic [7:0] bits;
  int reqCount;
  int nBits;
  int nData;
  task automatic half(input logic v);
    auxIn = v;
    repeat (DIV) @(posedge clk);
    #1;
  endtask
  task automatic sendByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      half(b[i]);
      half(~b[i]);
    end
  endtask
  initial auxIn = 1'b0;
  always begin
    @(posedge clk iff auxOe);
    reqCount = 0;
    nBits = 0;
    repeat (DIV / 2 - 1) @(posedge clk);
    // Sample the middle of each first half
    while (auxOe) begin
      bits = {bits[6:0], auxOut};
      nBits++;
      if (nBits % 8 == 0 && reqCount < 16) begin
        reqBytes[reqCount] = bits;
        reqCount++;
      end
      repeat (2 * DIV) @(posedge clk);
    end
    nData = (reqBytes[0][4] && reqCount > 3) ? reqBytes[3] + 1 : 0;
    if (!silent) begin
      repeat (replyDelay) @(posedge clk);
      #1;
      half(1'b1);
      sendByte({replyCode, 4'h0});
      if (replyCode == 4'h0) for (int i = 0; i < nData; i++) sendByte(8'hc0 + i[7:0]);
      auxIn = 1'b0;
    end
  end
endmodule

/* File: dv/tb_source_aux_link_training.sv */
// Purpose: register level bench of the sideband and training block
// Assumes: bready and rready held high, full byte strobes
// Notes: divisor set to 4 so sideband traffic stays short
`timescale 1ns/100ps
`include "source_aux_link_training_map.svh"
module tb_source_aux_link_training;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, st;
  logic [3:0] s_axi_wstrb, replyCode;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, lanePattern;
  logic auxIn, auxOut, auxOe, hpdIn, blankStart, silent;
  logic linkOutEnable, datapathBlocked, scramblerBypass, scramblerReinit, streamEnable;
  logic eventPending;
  logic [15:0] replyDelay;
  int mismatches = 0;
  int total_checks = 0;
  int reinitCount = 0;
  int n0;
  source_aux_link_training source_aux_link_training_inst (.clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .auxIn, .auxOut, .auxOe, .hpdIn,
    .blankStart, .linkOutEnable, .lanePattern, .datapathBlocked, .scramblerBypass,
    .scramblerReinit, .streamEnable, .eventPending);
  aux_sink_model #(.DIV(4)) aux_sink_model_inst (.clk, .auxOut, .auxOe, .replyCode, .silent,
    .replyDelay, .auxIn);
  always #2 clk = ~clk;
  always @(posedge clk) if (!rst && scramblerReinit === 1'b1) reinitCount++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A used-up wait is reported as a mismatch and ends the run
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      check(32'h1, 32'h0);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    int n = 0;
    @(negedge clk);
    s_axi_awaddr = a;
    s_axi_wdata = v;
    s_axi_awvalid = 1'b1;
    s_axi_wvalid = 1'b1;
    do begin @(posedge clk); n++; end while (s_axi_awready !== 1'b1 && n < 100);
    guard(n, 100);
    @(negedge clk);
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    while (s_axi_bvalid !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    guard(n, 100);
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, input logic [1:0] er);
    int n = 0;
    @(negedge clk);
    s_axi_araddr = a;
    s_axi_arvalid = 1'b1;
    do begin @(posedge clk); n++; end while (s_axi_arready !== 1'b1 && n < 100);
    guard(n, 100);
    @(negedge clk);
    s_axi_arvalid = 1'b0;
    while (s_axi_rvalid !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    guard(n, 100);
    v = s_axi_rdata;
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic waitReply(output logic [31:0] s);
    int n = 0;
    s = 32'h0;
    do begin rd(`OFS_EVT_STATUS, d, 2'b00); s = s | d; n++; end while (s[4:3] == 2'b00 && n < 1000);
    guard(n, 1000);
  endtask
  task automatic reqIs(input int cnt, input logic [47:0] exp);
    check(aux_sink_model_inst.reqCount, cnt);
    for (int i = 0; i < cnt; i++) check(aux_sink_model_inst.reqBytes[i], exp[47-8*i -: 8]);
  endtask
  task automatic blanks(input int k);
    repeat (k) begin
      @(negedge clk);
      blankStart = 1'b1;
      @(negedge clk);
      blankStart = 1'b0;
    end
  endtask
  // The first negedge lets a pending level left by an earlier status read fall
  task automatic hotPlug(input logic lvl, input logic [31:0] exp);
    int n = 0;
    @(negedge clk);
    hpdIn = lvl;
    while (eventPending !== 1'b1 && n < 20000) begin @(negedge clk); n++; end
    guard(n, 20000);
    rd(`OFS_EVT_STATUS, d, 2'b00);
    check(d, exp);
  endtask
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {hpdIn, blankStart, silent, replyCode} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    replyDelay = 16'h0014;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd(`OFS_SB_DIVISOR, d, 2'b00);
    check(d, 32'hfa);
    rd(`OFS_EVT_MASK, d, 2'b00);
    check(d, 32'h1f);
    check({31'h0, linkOutEnable}, 32'h0);
    wr(`OFS_SB_DIVISOR, 32'h4, 2'b00);
    wr(`OFS_LINK_OUT_EN, 32'h1, 2'b00);
    check({31'h0, linkOutEnable}, 32'h1);
    for (int p = 0; p < 4; p++) begin
      wr(`OFS_LINK_RATE, (p == 3) ? {24'h0, `LINK_RATE_TOP} : 32'h0a, 2'b00);
      wr(`OFS_TRAIN_PATTERN, (p == 3) ? 32'h2 : p, 2'b00);
      @(negedge clk);
      check({30'h0, lanePattern}, p);
      check({31'h0, datapathBlocked}, p != 0);
    end
    wr(`OFS_TRAIN_PATTERN, 32'h0, 2'b00);
    for (int v = 1; v >= 0; v--) begin
      wr(`OFS_SCRAMBLE_OFF, v, 2'b00);
      check({31'h0, scramblerBypass}, v);
    end
    n0 = reinitCount;
    wr(`OFS_SCR_RESET, 32'h1, 2'b00);
    repeat (4) @(negedge clk);
    check(reinitCount, n0 + 1);
    wr(`OFS_STREAM_EN, 32'h1, 2'b00);
    check({31'h0, streamEnable}, 32'h1);
    blanks(1024);
    repeat (2) @(negedge clk);
    check(reinitCount, n0 + 3);
    wr(`OFS_STREAM_EN, 32'h0, 2'b00);
    blanks(1024);
    check(reinitCount, n0 + 3);
    wr(`OFS_EVT_MASK, 32'h0, 2'b00);
    hotPlug(1'b0, 32'h2);
    hotPlug(1'b1, 32'h1);
    hpdIn = 1'b0;
    repeat (40) @(negedge clk);
    hotPlug(1'b1, 32'h4);
    wr(`OFS_SB_ADDRESS, 32'h00123, 2'b00);
    wr(`OFS_SB_WFIFO, 32'ha5, 2'b00);
    wr(`OFS_SB_WFIFO, 32'h3c, 2'b00);
    wr(`OFS_SB_COMMAND, 32'h800, 2'b00);
    wr(`OFS_TRAIN_PATTERN, 32'h2, 2'b00);
    waitReply(st);
    check(st[4:3], 2'b01);
    check({30'h0, lanePattern}, 32'h0);
    rd(`OFS_SB_RCODE, d, 2'b00);
    check(d, 32'h0);
    reqIs(6, 48'h800123_01a53c);
    replyDelay = 16'd300;
    wr(`OFS_SB_ADDRESS, 32'h00200, 2'b00);
    wr(`OFS_SB_COMMAND, 32'h903, 2'b00);
    waitReply(st);
    check(st[4:3], 2'b01);
    reqIs(4, 48'h900200_030000);
    rd(`OFS_SB_STATE, d, 2'b00);
    check(d, 32'h26);
    for (int i = 0; i < 4; i++) begin
      rd(`OFS_SB_RDATA, d, 2'b00);
      check(d[7:0], 8'hc0 + i);
    end
    replyCode = 4'h2;
    replyDelay = 16'h0014;
    wr(`OFS_SB_COMMAND, 32'h1400, 2'b00);
    waitReply(st);
    rd(`OFS_SB_RCODE, d, 2'b00);
    check(d, 32'h2);
    reqIs(3, 48'h400200_000000);
    silent = 1'b1;
    wr(`OFS_SB_COMMAND, 32'h1400, 2'b00);
    waitReply(st);
    check(st[4:3], 2'b10);
    rd(12'h200, d, 2'b10);
    wr(12'h200, 32'h0, 2'b10);
    end_of_test();
  end
endmodule
